// >>> mcs_pkg.sv
// Constants, types and field layouts for the clock select and chain config
package mcs_pkg;

  // Clock rate of clk_sys (internal oscillator domain)
  localparam longint unsigned CLK_HZ = 64'd40000000;
  // Least valid master clock frequency
  localparam longint unsigned MCLK_MIN_HZ = 64'd1150000;
  // Oscillator cycles in one master clock measurement window
  localparam int unsigned MEAS_CYC = 1024;
  // Least falling-edge count over the window (rounded up)
  localparam int unsigned MIN_EDGES =
    int'((MCLK_MIN_HZ * MEAS_CYC + CLK_HZ - 64'd1) / CLK_HZ);
  // Start-up routine length in oscillator cycles
  localparam int unsigned BOOT_CYC = 256;
  // Wideband group delay in output words
  localparam int unsigned WB_DELAY_WORDS = 34;
  // Sinc5 settling in output words
  localparam int unsigned SINC_DELAY_WORDS = 5;
  // Number of decimation settings
  localparam int unsigned DEC_SETTINGS = 6;

  // Register offsets
  localparam logic [7:0] OFS_CLK_IF = 8'h04;
  localparam logic [7:0] OFS_GEN_CFG = 8'h05;
  localparam logic [7:0] OFS_CH_STANDBY = 8'h08;
  localparam logic [7:0] OFS_REFP_BUF = 8'h09;
  localparam logic [7:0] OFS_REFN_BUF = 8'h0A;
  localparam logic [7:0] OFS_FILT_SEL = 8'h0B;
  localparam logic [7:0] OFS_DEC_RATE = 8'h0C;
  localparam logic [7:0] OFS_GROUP_B = 8'h0D;
  localparam logic [7:0] OFS_DEV_STATUS = 8'h0E;

  // Field positions
  localparam int unsigned CLK_IF_LVDS_BIT = 3;
  localparam int unsigned GEN_CM_EN_BIT = 4;
  localparam int unsigned GEN_CM_LVL_LSB = 0;
  localparam int unsigned DEC_A_LSB = 0;
  localparam int unsigned DEC_B_LSB = 4;
  localparam int unsigned STAT_CLK_ERR_BIT = 0;
  localparam int unsigned STAT_HANDOVER_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_CLK_IF = 8'h00;
  localparam logic [7:0] RST_GEN_CFG = 8'h10;
  localparam logic [7:0] RST_CH_STANDBY = 8'h00;
  localparam logic [7:0] RST_REF_BUF = 8'h00;
  localparam logic [7:0] RST_FILT_SEL = 8'hFF;
  localparam logic [7:0] RST_DEC_RATE = 8'h00;
  localparam logic [7:0] RST_GROUP_B = 8'h00;

  // Common-mode output level choices
  typedef enum logic [1:0] {
    CM_HALF_SUPPLY = 2'b00,
    CM_1V65 = 2'b01,
    CM_2V14 = 2'b10,
    CM_2V5 = 2'b11
  } mcs_cm_level_t;

  // Clock controller states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_MEASURE = 2'b01,
    ST_RUN = 2'b10,
    ST_FAULT = 2'b11
  } mcs_clk_state_t;

  // Configuration handed to the signal chain
  typedef struct packed {
    logic cmEnable;
    mcs_cm_level_t cmLevel;
    logic [7:0] refPosBufEn;
    logic [7:0] refNegBufEn;
    logic [7:0] wideband;
    logic [2:0] decCodeA;
    logic [2:0] decCodeB;
    logic [7:0] groupB;
  } mcs_chain_cfg_t;

  // Clock routing shown to the clock tree
  typedef struct packed {
    logic useExternal;
    logic lvdsMode;
    logic xtalOrLvds;
    logic clockFault;
  } mcs_clk_route_t;

endpackage

// >>> mcs_clock_chain_ctrl.sv
// Clock source selection, master clock check and chain configuration
//
// Functional notes
// - Pin mode: common-mode output on by default, at half supply.
// - Serial: register sets common-mode enable and one of four levels.
// - Channel zero standby forces the common-mode output off.
// - Pin mode: all reference precharge buffers off.
// - Positive and negative reference buffers set separately by host.
// - Boot on internal oscillator, then hand over to the master clock.
// - Count falling edges in a fixed window; valid from 1.15 MHz.
// - Failed check: no handover, header and status error, no data.
// - Clock fault stays until device reset.
// - Select pin low at power-up picks single-ended CMOS clock input.
// - Select high: crystal or LVDS; LVDS only serially, bit 3 of 0x04.
// - Sinc5 or wideband; per channel serially, one for all in pin mode.
// - Six decimation settings for both filters.
// - Wideband path group delay is about 34 output words.
// - After sync, settled data held back a fixed delay from sync rise.
// - Filters restart on sync rising edge; host issues it after setup.
`timescale 1ns/1ps
module mcs_clock_chain_ctrl #(
  parameter int unsigned BOOT_CYCLES = mcs_pkg::BOOT_CYC,
  parameter int unsigned MEAS_CYCLES = mcs_pkg::MEAS_CYC,
  parameter int unsigned MIN_EDGE_COUNT = mcs_pkg::MIN_EDGES,
  parameter int unsigned OSC_PER_MOD = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic extMclk,
  input wire logic clkSelPin,
  input wire logic pinMode,
  input wire logic pinFilterWide,
  input wire logic [2:0] pinDecCode,
  input wire logic syncIn,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output mcs_pkg::mcs_clk_route_t clkRoute,
  output mcs_pkg::mcs_chain_cfg_t chainCfg,
  output logic headerClkErr,
  output logic convEnable,
  output logic filterRestart,
  output logic settledValid
);

  // Elaboration-time checks
  initial
  begin
    if (MEAS_CYCLES < 2 || MEAS_CYCLES > 65535)
      $error("MEAS_CYCLES out of range");
    if (MIN_EDGE_COUNT < 1 || MIN_EDGE_COUNT > MEAS_CYCLES / 2)
      $error("MIN_EDGE_COUNT out of range");
    if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65536)
      $error("BOOT_CYCLES out of range");
    if (OSC_PER_MOD < 1 || OSC_PER_MOD > 64)
      $error("OSC_PER_MOD out of range");
  end

  // Decimation code to ratio; codes above the last setting give 1024
  function automatic logic [10:0] decRatio(input logic [2:0] code);
    logic [10:0] r;
    r = 11'h020;
    case (code)
      3'h0: r = 11'h020;
      3'h1: r = 11'h040;
      3'h2: r = 11'h080;
      3'h3: r = 11'h100;
      3'h4: r = 11'h200;
      default: r = 11'h400;
    endcase
    return r;
  endfunction

  // Settling delay in oscillator cycles for a filter and decimation
  function automatic logic [23:0] settleCycles(input logic wide,
                                               input logic [2:0] code);
    logic [23:0] words;
    words = wide ? 24'(mcs_pkg::WB_DELAY_WORDS) :
                   24'(mcs_pkg::SINC_DELAY_WORDS);
    return 24'(words * 24'(decRatio(code)) * 24'(OSC_PER_MOD));
  endfunction

  mcs_pkg::mcs_clk_state_t state_reg;
  mcs_pkg::mcs_clk_state_t state_next;
  logic strapTaken_reg;
  logic clkSel_reg;
  logic serialMode_reg;
  logic [7:0] clkIf_reg;
  logic [7:0] genCfg_reg;
  logic [7:0] standby_reg;
  logic [7:0] refPos_reg;
  logic [7:0] refNeg_reg;
  logic [7:0] filtSel_reg;
  logic [7:0] decRate_reg;
  logic [7:0] groupB_reg;
  logic [15:0] phaseCnt_reg;
  logic [15:0] edgeCnt_reg;
  logic mclkMeta_reg;
  logic mclkSync_reg;
  logic mclkPrev_reg;
  logic syncPrev_reg;
  logic [23:0] settleCnt_reg;
  logic settled_reg;
  logic mclkFall;
  logic syncRise;
  logic windowDone;
  logic [7:0] statusByte;
  logic regWrite;

  assign mclkFall = mclkPrev_reg & ~mclkSync_reg;
  assign syncRise = syncIn & ~syncPrev_reg;
  assign windowDone = (phaseCnt_reg == 16'(MEAS_CYCLES - 1));
  assign regWrite = regWrEn & serialMode_reg;

  // Straps caught once after reset release
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      strapTaken_reg <= 1'b0;
      clkSel_reg <= 1'b0;
      serialMode_reg <= 1'b0;
    end
    else if (!strapTaken_reg)
    begin
      strapTaken_reg <= 1'b1;
      clkSel_reg <= clkSelPin;
      serialMode_reg <= ~pinMode;
    end
  end

  // Master clock synchroniser and edge history
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mclkMeta_reg <= 1'b0;
      mclkSync_reg <= 1'b0;
      mclkPrev_reg <= 1'b0;
    end
    else
    begin
      mclkMeta_reg <= extMclk;
      mclkSync_reg <= mclkMeta_reg;
      mclkPrev_reg <= mclkSync_reg;
    end
  end

  // Clock controller next state; fault is left only by reset
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      mcs_pkg::ST_BOOT:
        if (strapTaken_reg && phaseCnt_reg == 16'(BOOT_CYCLES - 1))
          state_next = mcs_pkg::ST_MEASURE;
      mcs_pkg::ST_MEASURE:
        if (windowDone)
          state_next = (edgeCnt_reg + 16'(mclkFall) >=
                        16'(MIN_EDGE_COUNT)) ?
                       mcs_pkg::ST_RUN : mcs_pkg::ST_FAULT;
      mcs_pkg::ST_RUN:
        state_next = mcs_pkg::ST_RUN;
      mcs_pkg::ST_FAULT:
        state_next = mcs_pkg::ST_FAULT;
      default:
        state_next = mcs_pkg::ST_FAULT;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      state_reg <= mcs_pkg::ST_BOOT;
    else
      state_reg <= state_next;
  end

  // Boot timer and measurement window counter
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      phaseCnt_reg <= 16'h0000;
    else if (state_next != state_reg)
      phaseCnt_reg <= 16'h0000;
    else if (state_reg == mcs_pkg::ST_BOOT && strapTaken_reg)
      phaseCnt_reg <= phaseCnt_reg + 16'h0001;
    else if (state_reg == mcs_pkg::ST_MEASURE)
      phaseCnt_reg <= phaseCnt_reg + 16'h0001;
  end

  // Falling edges of the master clock inside the window
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      edgeCnt_reg <= 16'h0000;
    else if (state_reg != mcs_pkg::ST_MEASURE)
      edgeCnt_reg <= 16'h0000;
    else if (mclkFall)
      edgeCnt_reg <= edgeCnt_reg + 16'h0001;
  end

  // Register writes, accepted only in serial mode
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clkIf_reg <= mcs_pkg::RST_CLK_IF;
      genCfg_reg <= mcs_pkg::RST_GEN_CFG;
      standby_reg <= mcs_pkg::RST_CH_STANDBY;
      refPos_reg <= mcs_pkg::RST_REF_BUF;
      refNeg_reg <= mcs_pkg::RST_REF_BUF;
      filtSel_reg <= mcs_pkg::RST_FILT_SEL;
      decRate_reg <= mcs_pkg::RST_DEC_RATE;
      groupB_reg <= mcs_pkg::RST_GROUP_B;
    end
    else if (regWrite)
    begin
      case (regAddr)
        mcs_pkg::OFS_CLK_IF: clkIf_reg <= regWrData;
        mcs_pkg::OFS_GEN_CFG: genCfg_reg <= regWrData;
        mcs_pkg::OFS_CH_STANDBY: standby_reg <= regWrData;
        mcs_pkg::OFS_REFP_BUF: refPos_reg <= regWrData;
        mcs_pkg::OFS_REFN_BUF: refNeg_reg <= regWrData;
        mcs_pkg::OFS_FILT_SEL: filtSel_reg <= regWrData;
        mcs_pkg::OFS_DEC_RATE: decRate_reg <= regWrData;
        mcs_pkg::OFS_GROUP_B: groupB_reg <= regWrData;
        default: ;
      endcase
    end
  end

  // Device status byte
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[mcs_pkg::STAT_CLK_ERR_BIT] =
      (state_reg == mcs_pkg::ST_FAULT);
    statusByte[mcs_pkg::STAT_HANDOVER_BIT] = (state_reg == mcs_pkg::ST_RUN);
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else
    begin
      case (regAddr)
        mcs_pkg::OFS_CLK_IF: regRdData <= clkIf_reg;
        mcs_pkg::OFS_GEN_CFG: regRdData <= genCfg_reg;
        mcs_pkg::OFS_CH_STANDBY: regRdData <= standby_reg;
        mcs_pkg::OFS_REFP_BUF: regRdData <= refPos_reg;
        mcs_pkg::OFS_REFN_BUF: regRdData <= refNeg_reg;
        mcs_pkg::OFS_FILT_SEL: regRdData <= filtSel_reg;
        mcs_pkg::OFS_DEC_RATE: regRdData <= decRate_reg;
        mcs_pkg::OFS_GROUP_B: regRdData <= groupB_reg;
        mcs_pkg::OFS_DEV_STATUS: regRdData <= statusByte;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // Clock routing and fault reporting
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clkRoute <= '0;
      headerClkErr <= 1'b0;
      convEnable <= 1'b0;
    end
    else
    begin
      clkRoute.useExternal <= (state_next == mcs_pkg::ST_RUN);
      clkRoute.xtalOrLvds <= clkSel_reg;
      clkRoute.lvdsMode <= clkSel_reg & serialMode_reg &
                           clkIf_reg[mcs_pkg::CLK_IF_LVDS_BIT];
      clkRoute.clockFault <= (state_next == mcs_pkg::ST_FAULT);
      headerClkErr <= (state_next == mcs_pkg::ST_FAULT);
      convEnable <= (state_next == mcs_pkg::ST_RUN);
    end
  end

  // Chain configuration, pin mode defaults or register fields
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      chainCfg <= '0;
    else if (!serialMode_reg)
    begin
      chainCfg.cmEnable <= ~standby_reg[0];
      chainCfg.cmLevel <= mcs_pkg::CM_HALF_SUPPLY;
      chainCfg.refPosBufEn <= 8'h00;
      chainCfg.refNegBufEn <= 8'h00;
      chainCfg.wideband <= {8{pinFilterWide}};
      chainCfg.decCodeA <= pinDecCode;
      chainCfg.decCodeB <= pinDecCode;
      chainCfg.groupB <= 8'h00;
    end
    else
    begin
      chainCfg.cmEnable <= genCfg_reg[mcs_pkg::GEN_CM_EN_BIT] &
                           ~standby_reg[0];
      chainCfg.cmLevel <= mcs_pkg::mcs_cm_level_t'(
        genCfg_reg[mcs_pkg::GEN_CM_LVL_LSB +: 2]);
      chainCfg.refPosBufEn <= refPos_reg;
      chainCfg.refNegBufEn <= refNeg_reg;
      chainCfg.wideband <= filtSel_reg;
      chainCfg.decCodeA <= decRate_reg[mcs_pkg::DEC_A_LSB +: 3];
      chainCfg.decCodeB <= decRate_reg[mcs_pkg::DEC_B_LSB +: 3];
      chainCfg.groupB <= groupB_reg;
    end
  end

  // Sync edge detection and filter restart pulse
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      syncPrev_reg <= 1'b0;
      filterRestart <= 1'b0;
    end
    else
    begin
      syncPrev_reg <= syncIn;
      filterRestart <= syncRise & (state_reg == mcs_pkg::ST_RUN);
    end
  end

  // Settled data withheld after sync; slowest active setting decides
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      settleCnt_reg <= 24'h000000;
      settled_reg <= 1'b0;
    end
    else if (state_reg != mcs_pkg::ST_RUN)
    begin
      settleCnt_reg <= 24'h000000;
      settled_reg <= 1'b0;
    end
    else if (syncRise)
    begin
      settleCnt_reg <= settleCycles(|chainCfg.wideband,
        (chainCfg.groupB != 8'h00 &&
         chainCfg.decCodeB > chainCfg.decCodeA) ?
        chainCfg.decCodeB : chainCfg.decCodeA);
      settled_reg <= 1'b0;
    end
    else if (settleCnt_reg != 24'h000000)
      settleCnt_reg <= settleCnt_reg - 24'h000001;
    else
      settled_reg <= 1'b1;
  end

  assign settledValid = settled_reg & convEnable;

endmodule

// >>> mcs_mclk_source.sv
// Master clock source model driving the block's clock input
`timescale 1ns/1ps
module mcs_mclk_source (
  input wire logic [15:0] halfPeriodNs,
  output logic mclk
);
  // Free-running square wave at the rate the bench asks for
  initial
  begin
    mclk = 1'b0;
    forever #(halfPeriodNs) mclk = ~mclk;
  end
endmodule

// >>> mcs_clock_chain_ctrl_sva.sv
// Checker for the clock select and chain config block
`timescale 1ns/1ps
module mcs_clock_chain_ctrl_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pinMode,
  input wire logic syncIn,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire mcs_pkg::mcs_clk_route_t clkRoute,
  input wire mcs_pkg::mcs_chain_cfg_t chainCfg,
  input wire logic headerClkErr,
  input wire logic convEnable,
  input wire logic filterRestart,
  input wire logic settledValid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Serial write to the general configuration register
  sequence sGenWr;
    regWrEn && !pinMode && regAddr == mcs_pkg::OFS_GEN_CFG;
  endsequence
  // Sync rise once clocking is handed over
  sequence sSyncUp;
    $rose(syncIn) && convEnable;
  endsequence
  a_cm_level: assert property (
    sGenWr |-> ##2 chainCfg.cmLevel == $past(regWrData[1:0], 2))
    else $error("cm level not taken");
  a_standby_cm: assert property (
    regWrEn && !pinMode && regAddr == mcs_pkg::OFS_CH_STANDBY
    && regWrData[0] |-> ##2 !chainCfg.cmEnable)
    else $error("cm on in ch0 standby");
  a_sync_restart: assert property (
    sSyncUp |-> ##[1:3] filterRestart)
    else $error("no restart after sync");
  a_settle_hold: assert property (
    filterRestart |-> ##1 !settledValid [*2])
    else $error("settled data not withheld");
  a_fault_quiet: assert property (
    headerClkErr |-> clkRoute.clockFault && !convEnable && !filterRestart)
    else $error("activity in clock fault");
  a_fault_sticky: assert property (
    $rose(headerClkErr) |=> headerClkErr [*8])
    else $error("clock fault cleared");
  a_handover_ok: assert property (
    convEnable |-> clkRoute.useExternal && !headerClkErr)
    else $error("conversion without handover");
  a_pin_defaults: assert property (
    pinMode && convEnable |-> chainCfg.cmEnable && chainCfg.cmLevel == 2'h0
    && {chainCfg.refPosBufEn, chainCfg.refNegBufEn} == 16'h0000)
    else $error("pin mode defaults wrong");
endmodule
bind mcs_clock_chain_ctrl mcs_clock_chain_ctrl_sva i_sva (
  .clk_sys(clk_sys), .nrst(nrst), .pinMode(pinMode), .syncIn(syncIn),
  .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
  .clkRoute(clkRoute), .chainCfg(chainCfg), .headerClkErr(headerClkErr),
  .convEnable(convEnable), .filterRestart(filterRestart),
  .settledValid(settledValid));

// >>> mcs_clock_chain_ctrl_bench.sv
// Self-checking bench for the clock select and chain config block
`timescale 1ns/1ps
module mcs_clock_chain_ctrl_bench;
  logic clk_sys = 1'b0, nrst = 1'b0, clkSelPin = 1'b0, pinMode = 1'b0;
  logic pinFilterWide = 1'b0, syncIn = 1'b0, regWrEn = 1'b0, extMclk;
  logic [2:0] pinDecCode = 3'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [15:0] mclkHalf = 16'h0032;
  mcs_pkg::mcs_clk_route_t clkRoute;
  mcs_pkg::mcs_chain_cfg_t chainCfg;
  logic headerClkErr, convEnable, filterRestart, settledValid;
  int miscompares = 0, n_compared = 0;
  // Oscillator clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  // Master clock source and the design with short boot windows
  mcs_mclk_source i_mclk (.halfPeriodNs(mclkHalf), .mclk(extMclk));
  mcs_clock_chain_ctrl #(.BOOT_CYCLES(4), .MEAS_CYCLES(64),
    .MIN_EDGE_COUNT(2), .OSC_PER_MOD(4)) i_dut (.clk_sys(clk_sys),
    .nrst(nrst), .extMclk(extMclk), .clkSelPin(clkSelPin), .pinMode(pinMode),
    .pinFilterWide(pinFilterWide), .pinDecCode(pinDecCode), .syncIn(syncIn),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .clkRoute(clkRoute), .chainCfg(chainCfg),
    .headerClkErr(headerClkErr), .convEnable(convEnable),
    .filterRestart(filterRestart), .settledValid(settledValid));
  // Counts, verdict, end of run
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare and count, report a mismatch at once
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Let edges pass, then move off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // One register write, strobe held for a single edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    cyc(1);
    regWrEn = 1'b0;
    cyc(2);
  endtask
  // Register read against an expected byte
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    cyc(2);
    check(regRdData, exp);
  endtask
  // Reset with given straps, wait for the clock check to settle
  task automatic doReset(input logic sel, input logic pin,
    input logic [15:0] half);
    int i;
    nrst = 1'b0;
    clkSelPin = sel;
    pinMode = pin;
    mclkHalf = half;
    cyc(10);
    nrst = 1'b1;
    for (i = 0; i < 300 && convEnable !== 1'b1 && headerClkErr !== 1'b1; i++)
      cyc(1);
    check(i < 300, 1'b1);
    if (i == 300)
      results();
  endtask
  // Serial session: handover, registers, common mode, buffers, LVDS
  task automatic scnSerial();
    doReset(1'b1, 1'b0, 16'h0032);
    check(clkRoute, 4'hA);
    rd(mcs_pkg::OFS_DEV_STATUS, 8'h02);
    rd(mcs_pkg::OFS_GEN_CFG, mcs_pkg::RST_GEN_CFG);
    rd(8'h3F, 8'h00);
    for (int l = 0; l < 4; l++)
    begin
      wr(mcs_pkg::OFS_GEN_CFG, {6'h04, 2'(l)});
      check({chainCfg.cmEnable, chainCfg.cmLevel}, 16'(4 + l));
    end
    wr(mcs_pkg::OFS_CH_STANDBY, 8'h01);
    check(chainCfg.cmEnable, 1'b0);
    wr(mcs_pkg::OFS_CH_STANDBY, 8'h00);
    check(chainCfg.cmEnable, 1'b1);
    wr(mcs_pkg::OFS_GEN_CFG, 8'h03);
    check(chainCfg.cmEnable, 1'b0);
    wr(mcs_pkg::OFS_REFP_BUF, 8'hFF);
    check({chainCfg.refPosBufEn, chainCfg.refNegBufEn}, 16'hFF00);
    wr(mcs_pkg::OFS_FILT_SEL, 8'h0F);
    wr(mcs_pkg::OFS_DEC_RATE, 8'h52);
    check({chainCfg.wideband, 2'h0, chainCfg.decCodeB, chainCfg.decCodeA},
      16'h0F2A);
    wr(mcs_pkg::OFS_CLK_IF, 8'h08);
    check(clkRoute.lvdsMode, 1'b1);
  endtask
  // Sync restart and hold-off of settled data
  task automatic scnSync(input logic wide, input logic [2:0] ca,
    input logic [2:0] cb, input logic [7:0] grp);
    int n;
    int lim;
    logic hit;
    lim = (wide ? 34 : 5) * (32 << ((grp != 8'h00 && cb > ca) ? cb : ca)) * 4;
    hit = 1'b0;
    wr(mcs_pkg::OFS_FILT_SEL, {8{wide}});
    wr(mcs_pkg::OFS_DEC_RATE, {1'b0, cb, 1'b0, ca});
    wr(mcs_pkg::OFS_GROUP_B, grp);
    check(chainCfg.groupB, grp);
    syncIn = 1'b1;
    for (n = 1; n <= lim + 8 && !(n > 2 && settledValid === 1'b1); n++)
    begin
      cyc(1);
      syncIn = 1'b0;
      hit = hit | (filterRestart === 1'b1);
    end
    check(hit, 1'b1);
    check(n > lim && n < lim + 5, 1'b1);
    if (n > lim + 8)
      results();
  endtask
  // Pin mode: defaults, refused writes, one filter for all channels
  task automatic scnPin();
    pinFilterWide = 1'b1;
    pinDecCode = 3'h3;
    doReset(1'b0, 1'b1, 16'h0032);
    wr(mcs_pkg::OFS_GEN_CFG, 8'h00);
    wr(mcs_pkg::OFS_REFP_BUF, 8'hFF);
    check({chainCfg.cmEnable, chainCfg.cmLevel}, 16'h0004);
    check({chainCfg.refPosBufEn, chainCfg.refNegBufEn}, 16'h0000);
    check({chainCfg.wideband, chainCfg.decCodeA}, 16'h07FB);
    check(clkRoute, 4'h8);
    pinFilterWide = 1'b0;
    cyc(3);
    check(chainCfg.wideband, 8'h00);
  endtask
  // Slow master clock: fault latched until the next reset
  task automatic scnFault();
    doReset(1'b0, 1'b0, 16'h07D0);
    check({headerClkErr, convEnable, clkRoute}, 6'h21);
    rd(mcs_pkg::OFS_DEV_STATUS, 8'h01);
    mclkHalf = 16'h0032;
    syncIn = 1'b1;
    wr(mcs_pkg::OFS_GEN_CFG, 8'h10);
    syncIn = 1'b0;
    cyc(80);
    check({headerClkErr, convEnable}, 2'h2);
    doReset(1'b0, 1'b0, 16'h0032);
    check({headerClkErr, convEnable}, 2'h1);
  endtask
  // Scenario sequence
  initial
  begin
    scnSerial();
    scnSync(1'b0, 3'h0, 3'h0, 8'h00);
    scnSync(1'b1, 3'h0, 3'h3, 8'h00);
    scnSync(1'b0, 3'h0, 3'h1, 8'h01);
    scnSync(1'b0, 3'h5, 3'h0, 8'h00);
    scnPin();
    scnFault();
    results();
  end
endmodule
